// file: fvr_recorder.sv
// Fault value recorder: current stacks, duration timers, demand and display
`default_nettype none
module fvr_recorder
  import fvr_pkg::*;
#(
  parameter longint DEMAND_PERIOD_CYC = fvr_pkg::DEMAND_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [fvr_pkg::NUM_STAGES-1:0] stage_start,
  input wire logic [fvr_pkg::NUM_STAGES-1:0] stage_trip,
  input wire logic [fvr_pkg::VAL_W-1:0] phase_one_current,
  input wire logic [fvr_pkg::VAL_W-1:0] phase_two_current,
  input wire logic [fvr_pkg::VAL_W-1:0] phase_three_current,
  input wire logic [fvr_pkg::VAL_W-1:0] neutral_current,
  input wire logic [fvr_pkg::NUM_STAGES*16-1:0] operate_time_ticks,
  input wire logic inverse_time_mode,
  input wire logic [15:0] inverse_operate_ticks,
  input wire logic blocking_input,
  input wire logic key_reset,
  input wire logic key_program,
  input wire logic aux_power_lost,
  input wire logic [3:0] sel_register,
  input wire logic [2:0] sel_position,
  input wire logic sel_submenu,
  output logic [3:0] disp_address,
  output logic [fvr_pkg::VAL_W-1:0] disp_value
);
  import fvr_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [VAL_W-1:0] stk_ff [0:7][0:STACK_DEPTH-1]; // 0-2 phases, 3 neutral, 4-7 durations
  logic [15:0] tick_ff [0:NUM_STAGES-1];
  logic [7:0] starts_ff [0:NUM_STAGES-1];
  logic [NUM_STAGES-1:0] start_q_ff;
  logic [NUM_STAGES-1:0] trip_q_ff;
  logic [NUM_STAGES-1:0] timing_ff;
  logic [VAL_W-1:0] demand_ff;
  logic [VAL_W-1:0] demand_peak_ff;
  logic [VAL_W+3:0] acc_ff;
  logic [4:0] samp_ff;
  logic [63:0] dcnt_ff;
  fvr_mode_e mode_ff;
  logic clear;
  logic phase_cap;
  logic earth_cap;
  logic [NUM_STAGES-1:0] new_start;
  logic [NUM_STAGES-1:0] trip_edge;
  logic phase_refresh;
  logic earth_refresh;
  logic [VAL_W-1:0] top_phase;
  logic [VAL_W-1:0] nxt_value;

  // Highest of two currents
  function automatic logic [VAL_W-1:0] fvr_max(input logic [VAL_W-1:0] a,
                                               input logic [VAL_W-1:0] b);
    begin
      fvr_max = (a > b) ? a : b;
    end
  endfunction

  // Elapsed ticks as percent of operate time, capped below 100 while running
  function automatic logic [VAL_W-1:0] fvr_pct(input logic [15:0] ticks,
                                               input logic [15:0] limit);
    logic [31:0] p;
    begin
      p = 32'h0;
      if (limit != 16'h0000)
        p = ({16'h0000, ticks} * 32'h00000064) / {16'h0000, limit};
      fvr_pct = (p > 32'h00000063) ? 12'h063 : p[VAL_W-1:0];
    end
  endfunction

  // ****************************************
  // Event detection and clear control
  // ****************************************
  // Both keys together or a supply loss wipe the recorded data
  assign clear = (key_reset & key_program) | aux_power_lost;
  assign new_start = stage_start & ~start_q_ff;
  assign trip_edge = stage_trip & ~trip_q_ff;
  // A trip with no start in force opens an entry of its own
  assign phase_cap = |((new_start | (trip_edge & ~stage_start)) & 4'b0011);
  assign earth_cap = |((new_start | (trip_edge & ~stage_start)) & 4'b1100);
  // A trip during a start rewrites that start's entry, so one fault fills one slot
  assign phase_refresh = |(trip_edge & stage_start & start_q_ff & 4'b0011);
  assign earth_refresh = |(trip_edge & stage_start & start_q_ff & 4'b1100);
  assign top_phase = fvr_max(fvr_max(phase_one_current, phase_two_current),
                             phase_three_current);

  // Edge history of starts and trips
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      start_q_ff <= '0;
      trip_q_ff <= '0;
    end
    else
    begin
      start_q_ff <= stage_start;
      trip_q_ff <= stage_trip;
    end
  end

  // Mode tracks whether a clear is in progress
  always_ff @(posedge mclk)
  begin
    if (rst)
      mode_ff <= FVR_RUN;
    else
      mode_ff <= clear ? FVR_CLR : FVR_RUN;
  end

  // ****************************************
  // History stacks
  // ****************************************
  // Index 0 is newest; entries move up, index 4 falls off the top
  always_ff @(posedge mclk)
  begin
    if (rst || clear)
    begin
      for (int s = 0; s < 8; s++)
        for (int d = 0; d < STACK_DEPTH; d++)
          stk_ff[s][d] <= VAL_ZERO;
    end
    else
    begin
      if (phase_cap)
      begin
        for (int d = STACK_DEPTH-1; d > 0; d--)
        begin
          stk_ff[0][d] <= stk_ff[0][d-1];
          stk_ff[1][d] <= stk_ff[1][d-1];
          stk_ff[2][d] <= stk_ff[2][d-1];
        end
        stk_ff[0][0] <= phase_one_current;
        stk_ff[1][0] <= phase_two_current;
        stk_ff[2][0] <= phase_three_current;
      end
      else if (phase_refresh)
      begin
        stk_ff[0][0] <= phase_one_current;
        stk_ff[1][0] <= phase_two_current;
        stk_ff[2][0] <= phase_three_current;
      end
      if (earth_cap)
      begin
        for (int d = STACK_DEPTH-1; d > 0; d--)
          stk_ff[3][d] <= stk_ff[3][d-1];
        stk_ff[3][0] <= neutral_current;
      end
      else if (earth_refresh)
        stk_ff[3][0] <= neutral_current;
      // Duration stacks sit above the neutral one; a new start pushes the finished value
      for (int g = 0; g < NUM_STAGES; g++)
      begin
        if (new_start[g])
        begin
          for (int d = STACK_DEPTH-1; d > 0; d--)
            stk_ff[4+g][d] <= stk_ff[4+g][d-1];
          stk_ff[4+g][0] <= VAL_ZERO;
        end
        else if (timing_ff[g])
        begin
          if (stage_trip[g])
            stk_ff[4+g][0] <= PCT_FULL;
          else
            stk_ff[4+g][0] <= fvr_pct(tick_ff[g],
              (g == STG_LP && inverse_time_mode) ? inverse_operate_ticks
                                                 : operate_time_ticks[g*16 +: 16]);
        end
      end
    end
  end

  // Duration tick counters and start counts
  always_ff @(posedge mclk)
  begin
    if (rst || clear)
    begin
      timing_ff <= '0;
      for (int g = 0; g < NUM_STAGES; g++)
      begin
        tick_ff[g] <= 16'h0000;
        starts_ff[g] <= 8'h00;
      end
    end
    else
    begin
      for (int g = 0; g < NUM_STAGES; g++)
      begin
        if (new_start[g])
        begin
          tick_ff[g] <= 16'h0000;
          timing_ff[g] <= 1'b1;
          if (starts_ff[g] != START_MAX)
            starts_ff[g] <= starts_ff[g] + 8'h01;
        end
        else if (timing_ff[g])
        begin
          if (stage_trip[g] || !stage_start[g])
            timing_ff[g] <= 1'b0; // Value frozen once the start drops or trips
          else if (tick_ff[g] != 16'hFFFF)
            tick_ff[g] <= tick_ff[g] + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // Maximum demand
  // ****************************************
  // Mean of 16 samples spread over the period; avoids a huge accumulator
  always_ff @(posedge mclk)
  begin
    if (rst || clear)
    begin
      dcnt_ff <= 64'h0;
      samp_ff <= 5'h00;
      acc_ff <= '0;
      demand_ff <= VAL_ZERO;
      demand_peak_ff <= VAL_ZERO;
    end
    else if (dcnt_ff >= 64'(DEMAND_PERIOD_CYC / DEMAND_SAMPLES) - 64'h1)
    begin
      dcnt_ff <= 64'h0;
      if (samp_ff == 5'(DEMAND_SAMPLES - 1))
      begin
        samp_ff <= 5'h00;
        acc_ff <= '0;
        demand_ff <= 12'((acc_ff + 16'(top_phase)) >> 4);
        demand_peak_ff <= fvr_max(demand_peak_ff,
                                  12'((acc_ff + 16'(top_phase)) >> 4));
      end
      else
      begin
        samp_ff <= samp_ff + 5'h01;
        acc_ff <= acc_ff + 16'(top_phase);
      end
    end
    else
      dcnt_ff <= dcnt_ff + 64'h1;
  end

  // ****************************************
  // Display
  // ****************************************
  // Select the value shown for the chosen register and position
  always_comb
  begin
    nxt_value = VAL_ZERO;
    unique case (sel_register)
      REG_BLOCK: nxt_value = {11'h000, blocking_input};
      REG_PH1: nxt_value = stk_ff[0][sel_position];
      REG_PH2: nxt_value = stk_ff[1][sel_position];
      REG_PH3: nxt_value = stk_ff[2][sel_position];
      REG_DEMAND: nxt_value = sel_submenu ? demand_peak_ff : demand_ff;
      REG_DUR_LP: nxt_value = sel_submenu ? 12'(starts_ff[0]) : stk_ff[4][sel_position];
      REG_DUR_HP: nxt_value = sel_submenu ? 12'(starts_ff[1]) : stk_ff[5][sel_position];
      REG_NEUTRAL: nxt_value = stk_ff[3][sel_position];
      REG_DUR_LE: nxt_value = sel_submenu ? 12'(starts_ff[2]) : stk_ff[6][sel_position];
      REG_DUR_HE: nxt_value = sel_submenu ? 12'(starts_ff[3]) : stk_ff[7][sel_position];
      default: nxt_value = VAL_ZERO;
    endcase
    if (sel_position >= 3'(STACK_DEPTH))
      nxt_value = (sel_register == REG_BLOCK || sel_register == REG_DEMAND) ? nxt_value : VAL_ZERO;
  end

  // Registered display drive
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      disp_address <= 4'h0;
      disp_value <= VAL_ZERO;
    end
    else
    begin
      disp_address <= sel_register;
      disp_value <= nxt_value;
    end
  end
endmodule
`default_nettype wire

// file: fvr_pkg.sv
// Package of constants and types for the fault value recorder
`default_nettype none
package fvr_pkg;
  // ****************************************
  // Widths, depths and register addresses
  // ****************************************
  localparam int VAL_W = 12;
  localparam int STACK_DEPTH = 5;
  localparam int NUM_STAGES = 4;
  localparam logic [3:0] REG_BLOCK = 4'h0;
  localparam logic [3:0] REG_PH1 = 4'h1;
  localparam logic [3:0] REG_PH2 = 4'h2;
  localparam logic [3:0] REG_PH3 = 4'h3;
  localparam logic [3:0] REG_DEMAND = 4'h4;
  localparam logic [3:0] REG_DUR_LP = 4'h5;
  localparam logic [3:0] REG_DUR_HP = 4'h6;
  localparam logic [3:0] REG_NEUTRAL = 4'h7;
  localparam logic [3:0] REG_DUR_LE = 4'h8;
  localparam logic [3:0] REG_DUR_HE = 4'h9;
  // Stage indices: low/high phase, low/high earth
  localparam int STG_LP = 0;
  localparam int STG_HP = 1;
  localparam int STG_LE = 2;
  localparam int STG_HE = 3;
  // ****************************************
  // Values and timing
  // ****************************************
  localparam logic [VAL_W-1:0] PCT_FULL = 12'h064;
  localparam logic [7:0] START_MAX = 8'hFF;
  localparam logic [VAL_W-1:0] VAL_ZERO = 12'h000;
  localparam int CLK_HZ = 50000000;
  localparam int DEMAND_MIN = 15;
  localparam longint DEMAND_CYC = longint'(DEMAND_MIN) * 60 * longint'(CLK_HZ);
  localparam int DEMAND_SAMPLES = 16;
  // Clear-state machine
  typedef enum logic [1:0] {
    FVR_RUN = 2'b01,
    FVR_CLR = 2'b10
  } fvr_mode_e;
endpackage
`default_nettype wire

// file: fvr_sva.sv
// Port checker for the fault value recorder
`default_nettype none
module fvr_sva
  import fvr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [fvr_pkg::NUM_STAGES-1:0] stage_start,
  input wire logic [fvr_pkg::NUM_STAGES-1:0] stage_trip,
  input wire logic blocking_input,
  input wire logic key_reset,
  input wire logic key_program,
  input wire logic aux_power_lost,
  input wire logic [3:0] sel_register,
  input wire logic [2:0] sel_position,
  input wire logic sel_submenu,
  input wire logic [3:0] disp_address,
  input wire logic [fvr_pkg::VAL_W-1:0] disp_value
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Checks
  // ****************************************
  logic quiet;
  logic rec;
  logic top;
  // Demand is left out of the clear checks, though a clear also holds its period counter and values at zero
  assign quiet = (stage_start == 4'h0) && (stage_trip == 4'h0);
  assign rec = (sel_register inside {[4'h1:4'h9]}) && (sel_register != REG_DEMAND);
  assign top = (sel_position == 3'h0) && !sel_submenu;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_addr_shown: assert property ($stable(sel_register)[*3] |-> disp_address == sel_register)
    else $error("address digit wrong");
  a_block_one: assert property ((sel_register == REG_BLOCK && blocking_input)[*3] |-> disp_value == 12'h001)
    else $error("blocking shown wrong");
  a_block_zero: assert property ((sel_register == REG_BLOCK && !blocking_input)[*3] |-> disp_value == 12'h000)
    else $error("no blocking shown wrong");
  a_keys_clear: assert property ((key_reset && key_program && quiet && rec)[*3] |-> disp_value == 12'h000)
    else $error("keys did not clear");
  a_power_clear: assert property ((aux_power_lost && quiet && rec)[*3] |-> disp_value == 12'h000)
    else $error("power loss did not clear");
  a_lp_trip_full: assert property ((stage_trip[STG_LP] && sel_register == REG_DUR_LP && top)[*3] |-> disp_value == PCT_FULL)
    else $error("low phase trip not full");
  a_hp_trip_full: assert property ((stage_trip[STG_HP] && sel_register == REG_DUR_HP && top)[*3] |-> disp_value == PCT_FULL)
    else $error("high phase trip not full");
  a_he_trip_full: assert property ((stage_trip[STG_HE] && sel_register == REG_DUR_HE && top)[*3] |-> disp_value == PCT_FULL)
    else $error("high earth trip not full");
endmodule
bind fvr_recorder fvr_sva u_fvr_sva (.mclk(mclk), .rst(rst), .stage_start(stage_start),
  .stage_trip(stage_trip), .blocking_input(blocking_input), .key_reset(key_reset),
  .key_program(key_program), .aux_power_lost(aux_power_lost), .sel_register(sel_register),
  .sel_position(sel_position), .sel_submenu(sel_submenu), .disp_address(disp_address),
  .disp_value(disp_value));
`default_nettype wire

// file: fvr_stage_model.sv
// Behavioural model of the protection stages raising start and trip
`default_nettype none
module fvr_stage_model
(
  input wire logic mclk,
  input wire logic req,
  input wire logic [1:0] req_stage,
  input wire logic [7:0] req_len,
  input wire logic req_trip,
  output logic [3:0] stage_start,
  output logic [3:0] stage_trip,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int left_ff = 0;
  int trip_ff = 0;
  logic [1:0] stg_ff = 2'h0;
  logic [3:0] start_v;
  logic [3:0] trip_v;
  // Start lasts the asked span; a trip then holds four cycles so it can be read
  always @(negedge mclk)
  begin
    if (req)
    begin
      stg_ff = req_stage;
      left_ff = int'(req_len);
      trip_ff = req_trip ? 4 : 0;
    end
    else if (left_ff > 0)
      left_ff = left_ff - 1;
    else if (trip_ff > 0)
      trip_ff = trip_ff - 1;
    // Build the one-hot pattern first so each output changes once per step
    start_v = 4'h0;
    trip_v = 4'h0;
    start_v[stg_ff] = (left_ff > 0) || (trip_ff > 0);
    trip_v[stg_ff] = (left_ff == 0) && (trip_ff > 0);
    stage_start = start_v;
    stage_trip = trip_v;
  end
  assign busy = (left_ff > 0) || (trip_ff > 0);
endmodule
`default_nettype wire

// file: fvr_recorder_tb.sv
// Self-checking testbench for the fault value recorder
`default_nettype none
module fvr_recorder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fvr_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic [1:0] req_stage = 2'h0;
  logic [7:0] req_len = 8'h00;
  logic req_trip = 1'b0;
  logic busy;
  logic [3:0] stage_start;
  logic [3:0] stage_trip;
  logic [11:0] phase_one_current = 12'h000;
  logic [11:0] phase_two_current = 12'h000;
  logic [11:0] phase_three_current = 12'h000;
  logic [11:0] neutral_current = 12'h000;
  logic inverse_time_mode = 1'b0;
  logic blocking_input = 1'b0;
  logic key_reset = 1'b0;
  logic key_program = 1'b0;
  logic aux_power_lost = 1'b0;
  logic [3:0] sel_register = 4'h0;
  logic [2:0] sel_position = 3'h0;
  logic sel_submenu = 1'b0;
  logic [3:0] disp_address;
  logic [11:0] disp_value;
  int fails = 0;
  int check_count = 0;
  // Demand period shortened to keep the run brief
  fvr_recorder #(.DEMAND_PERIOD_CYC(64)) u_fvr_recorder (.mclk(mclk), .rst(rst),
    .stage_start(stage_start), .stage_trip(stage_trip), .phase_one_current(phase_one_current),
    .phase_two_current(phase_two_current), .phase_three_current(phase_three_current),
    .neutral_current(neutral_current), .operate_time_ticks(64'h0014_0014_0014_0014),
    .inverse_time_mode(inverse_time_mode), .inverse_operate_ticks(16'h0064),
    .blocking_input(blocking_input), .key_reset(key_reset), .key_program(key_program),
    .aux_power_lost(aux_power_lost), .sel_register(sel_register), .sel_position(sel_position),
    .sel_submenu(sel_submenu), .disp_address(disp_address), .disp_value(disp_value));
  fvr_stage_model u_fvr_stage_model (.mclk(mclk), .req(req), .req_stage(req_stage),
    .req_len(req_len), .req_trip(req_trip), .stage_start(stage_start),
    .stage_trip(stage_trip), .busy(busy));
  // Free-running clock
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  task automatic stop_test();
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Select a display item and read it once the selection has settled
  task automatic rd(input logic [3:0] r, input logic [2:0] p, input logic s,
    output logic [11:0] v);
    @(negedge mclk);
    sel_register <= r;
    sel_position <= p;
    sel_submenu <= s;
    repeat (3) @(negedge mclk);
    v = disp_value;
  endtask
  // Ask the stage model for one start, polled at rising edges where it never moves
  task automatic ev(input int st, input int len, input logic tr);
    int i;
    @(negedge mclk);
    req <= 1'b1;
    req_stage <= st[1:0];
    req_len <= len[7:0];
    req_trip <= tr;
    @(negedge mclk);
    req <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 300 && busy; i++) @(posedge mclk);
    repeat (2) @(negedge mclk);
  endtask
  task automatic clr();
    @(negedge mclk);
    sel_register <= REG_PH1;
    key_reset <= 1'b1;
    key_program <= 1'b1;
    repeat (4) @(negedge mclk);
    key_reset <= 1'b0;
    key_program <= 1'b0;
  endtask
  task automatic t_display();
    logic [11:0] v;
    blocking_input <= 1'b1;
    rd(REG_BLOCK, 3'h0, 1'b0, v);
    chk(v, 12'h001);
    blocking_input <= 1'b0;
    rd(REG_BLOCK, 3'h0, 1'b0, v);
    chk(v, 12'h000);
    rd(REG_DUR_HE, 3'h0, 1'b0, v);
    chk({8'h00, disp_address}, 12'h009);
  endtask
  task automatic t_stack();
    logic [11:0] v;
    clr();
    for (int k = 1; k <= 6; k++)
    begin
      phase_one_current <= 12'(k);
      phase_two_current <= 12'(16 + k);
      phase_three_current <= 12'(32 + k);
      ev(STG_LP, 2, 1'b0);
      if (k == 2)
      begin
        rd(REG_PH1, 3'h2, 1'b0, v);
        chk(v, 12'h000);
      end
    end
    for (int p = 0; p < 5; p++)
      for (int r = 1; r <= 3; r++)
      begin
        rd(4'(r), 3'(p), 1'b0, v);
        chk(v, 12'(16 * (r - 1) + 6 - p));
      end
    neutral_current <= 12'h0C8;
    ev(STG_LE, 2, 1'b0);
    rd(REG_NEUTRAL, 3'h0, 1'b0, v);
    chk(v, 12'h0C8);
  endtask
  task automatic trip_one(input int st, input logic [3:0] r);
    logic [11:0] v;
    clr();
    rd(r, 3'h0, 1'b0, v);
    ev(st, 3, 1'b1);
    rd(r, 3'h0, 1'b0, v);
    chk(v, PCT_FULL);
    rd(r, 3'h0, 1'b1, v);
    chk(v, 12'h001);
    rd(REG_PH1, 3'h1, 1'b0, v);
    chk(v, VAL_ZERO);
  endtask
  task automatic t_timing();
    logic [11:0] v;
    trip_one(STG_LP, REG_DUR_LP);
    trip_one(STG_HP, REG_DUR_HP);
    trip_one(STG_HE, REG_DUR_HE);
    inverse_time_mode <= 1'b1;
    ev(STG_LP, 50, 1'b0);
    ev(STG_LP, 10, 1'b0);
    rd(REG_DUR_LP, 3'h1, 1'b0, v);
    check_count++;
    if ((v >= 12'h02D && v <= 12'h037) !== 1'b1)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, v, 12'h032);
    end
    for (int n = 0; n < 257; n++) ev(STG_HP, 1, 1'b0);
    rd(REG_DUR_HP, 3'h0, 1'b1, v);
    chk(v, 12'h0FF);
  endtask
  task automatic t_demand();
    logic [11:0] v;
    phase_one_current <= 12'h010;
    phase_two_current <= 12'h030;
    phase_three_current <= 12'h020;
    repeat (200) @(negedge mclk);
    rd(REG_DEMAND, 3'h0, 1'b0, v);
    chk(v, 12'h030);
    phase_one_current <= 12'h000;
    phase_two_current <= 12'h000;
    phase_three_current <= 12'h000;
    repeat (200) @(negedge mclk);
    rd(REG_DEMAND, 3'h0, 1'b1, v);
    chk(v, 12'h030);
    rd(REG_PH1, 3'h0, 1'b0, v);
    aux_power_lost <= 1'b1;
    repeat (4) @(negedge mclk);
    aux_power_lost <= 1'b0;
    rd(REG_PH1, 3'h0, 1'b0, v);
    chk(v, 12'h000);
    rd(REG_DEMAND, 3'h0, 1'b1, v);
    chk(v, 12'h000);
  endtask
  // Main sequence after five cycles of reset
  initial
  begin
    repeat (5) @(negedge mclk);
    rst <= 1'b0;
    t_display();
    t_stack();
    t_timing();
    t_demand();
    stop_test();
  end
  // Watchdog well past the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
